/* File: verilog/pbir_pkg.sv */
// Constants and types for the pin block input register
package pbir_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W = 11;

    // Register offsets
    localparam logic [ADDR_W-1:0] CFG_OFFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFFS = 8'h04;

    // Configuration field positions
    localparam int CFG_A_REG_BIT = 0;
    localparam int CFG_B_REG_BIT = 1;
    localparam int CFG_LATCH_BIT = 2;
    localparam int CFG_CLK_INV_BIT = 3;
    localparam int CFG_CE_IN_BIT = 4;
    localparam int CFG_CE_OUT_BIT = 5;
    localparam int CFG_CE_USED_BIT = 6;
    localparam int CFG_INIT_SET_BIT = 7;
    localparam int CFG_DIR_LSB = 8;
    localparam int CFG_OUT_REG_BIT = 10;

    // Enable reaches both elements, enable pin unconnected, init is reset
    localparam logic [CFG_W-1:0] CFG_RST = 11'h030;

    // Status field positions
    localparam int STAT_PAD_BIT = 0;
    localparam int STAT_IN_Q_BIT = 1;
    localparam int STAT_OUT_Q_BIT = 2;
    localparam int STAT_PATH_A_BIT = 3;
    localparam int STAT_PATH_B_BIT = 4;
    localparam int STAT_W = 5;

    // Pin direction
    typedef enum logic [1:0] {
        PBIR_DIR_IN = 2'b00,
        PBIR_DIR_OUT = 2'b01,
        PBIR_DIR_BIDIR = 2'b10
    } pbir_dir_e;

endpackage

/* File: verilog/pbir_store_cell.sv */
// Storage element usable as flip-flop or latch with init value
`timescale 1ns/10ps
module pbir_store_cell (
    // Clock and resets
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic gsr_i,
    // Configuration
    input wire logic latch_mode_i,
    input wire logic clk_inv_i,
    input wire logic init_set_i,
    // Element inputs
    input wire logic ce_i,
    input wire logic gate_i,
    input wire logic d_i,
    // Element output
    output logic q_o
);

    logic gate_eff;
    logic gate_r;
    logic q_r;

    assign gate_eff = gate_i ^ clk_inv_i;

    // Previous gate level, for edge detection on a sampled clock
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= gate_eff;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_r <= 1'b0; // Power-up always loads the reset value
        end else if (gsr_i) begin
            q_r <= init_set_i;
        end else if (ce_i) begin
            if (latch_mode_i) begin
                if (gate_eff) begin
                    q_r <= d_i;
                end
            end else if (gate_eff && !gate_r) begin
                q_r <= d_i;
            end
        end
    end

    assign q_o = q_r;

endmodule // pbir_store_cell

/* File: verilog/pbir_pin_block.sv */
// Pin block: input capture paths, output driver and config registers
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module pbir_pin_block (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [pbir_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pbir_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pbir_pkg::DATA_W-1:0] reg_rdata_o,
    // Package pin
    input wire logic pad_in_i,
    output logic pad_out_o,
    output logic pad_oe_o,
    // Array side controls
    input wire logic global_set_reset_i,
    input wire logic in_clk_i,
    input wire logic out_clk_i,
    input wire logic clk_en_i,
    input wire logic out_data_i,
    input wire logic out_tri_i,
    // Array side input paths
    output logic array_input_path_a_o,
    output logic array_input_path_b_o
);

    logic [pbir_pkg::CFG_W-1:0] cfg_r;
    logic [pbir_pkg::DATA_W-1:0] rdata_r;
    logic [pbir_pkg::DATA_W-1:0] rdata_nxt;
    logic [pbir_pkg::STAT_W-1:0] stat;
    logic path_a_r;
    logic path_b_r;
    logic pad_out_r;
    logic pad_oe_r;
    logic pad_oe_nxt;
    logic pad_seen_r;
    logic ce_line;
    logic in_ce;
    logic out_ce;
    logic in_q;
    logic out_q;
    pbir_pkg::pbir_dir_e dir;

    // Configuration fields
    logic a_reg;
    logic b_reg;
    logic latch_mode;
    logic clk_inv;
    logic ce_to_in;
    logic ce_to_out;
    logic ce_used;
    logic init_set;
    logic out_reg;

    assign a_reg = cfg_r[pbir_pkg::CFG_A_REG_BIT];
    assign b_reg = cfg_r[pbir_pkg::CFG_B_REG_BIT];
    assign latch_mode = cfg_r[pbir_pkg::CFG_LATCH_BIT];
    assign clk_inv = cfg_r[pbir_pkg::CFG_CLK_INV_BIT];
    assign ce_to_in = cfg_r[pbir_pkg::CFG_CE_IN_BIT];
    assign ce_to_out = cfg_r[pbir_pkg::CFG_CE_OUT_BIT];
    assign ce_used = cfg_r[pbir_pkg::CFG_CE_USED_BIT];
    assign init_set = cfg_r[pbir_pkg::CFG_INIT_SET_BIT];
    assign out_reg = cfg_r[pbir_pkg::CFG_OUT_REG_BIT];
    assign dir = pbir_pkg::pbir_dir_e'(cfg_r[pbir_pkg::CFG_DIR_LSB +: 2]);

    // Configuration register, written whole; upper data bits are ignored
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg_r <= pbir_pkg::CFG_RST;
        end else if (reg_wr_i && reg_addr_i == pbir_pkg::CFG_OFFS) begin
            cfg_r <= reg_wdata_i[pbir_pkg::CFG_W-1:0];
        end
    end

    // enable is active high, never inverted
    assign ce_line = ce_used ? clk_en_i : 1'b1;

    assign in_ce = ce_to_in ? ce_line : 1'b1;
    assign out_ce = ce_to_out ? ce_line : 1'b1;

    pbir_store_cell u_in_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .gsr_i(global_set_reset_i),
        .latch_mode_i(latch_mode),
        .clk_inv_i(clk_inv),
        .init_set_i(init_set),
        .ce_i(in_ce),
        .gate_i(in_clk_i),
        .d_i(pad_in_i),
        .q_o(in_q)
    );

    // Output element is always a rising-edge flip-flop
    pbir_store_cell u_out_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .gsr_i(global_set_reset_i),
        .latch_mode_i(1'b0),
        .clk_inv_i(1'b0),
        .init_set_i(init_set),
        .ce_i(out_ce),
        .gate_i(out_clk_i),
        .d_i(out_data_i),
        .q_o(out_q)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            path_a_r <= 1'b0;
            path_b_r <= 1'b0;
        end else begin
            path_a_r <= a_reg ? in_q : pad_in_i;
            path_b_r <= b_reg ? in_q : pad_in_i;
        end
    end

    always_comb begin
        case (dir)
            pbir_pkg::PBIR_DIR_IN: pad_oe_nxt = 1'b0;
            pbir_pkg::PBIR_DIR_OUT: pad_oe_nxt = 1'b1;
            pbir_pkg::PBIR_DIR_BIDIR: pad_oe_nxt = !out_tri_i;
            default: pad_oe_nxt = 1'b0; // Unused code is a safe input
        endcase
    end

    // Pin drive; registered so the pad never sees combinational glitches
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pad_out_r <= 1'b0;
            pad_oe_r <= 1'b0;
        end else begin
            pad_out_r <= out_reg ? out_q : out_data_i;
            pad_oe_r <= pad_oe_nxt;
        end
    end

    // Sampled pin level for status reads
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pad_seen_r <= 1'b0;
        end else begin
            pad_seen_r <= pad_in_i;
        end
    end

    // Status word
    assign stat = {path_b_r, path_a_r, out_q, in_q, pad_seen_r};

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = '0;
        if (reg_addr_i == pbir_pkg::CFG_OFFS) begin
            rdata_nxt[pbir_pkg::CFG_W-1:0] = cfg_r;
        end else if (reg_addr_i == pbir_pkg::STAT_OFFS) begin
            rdata_nxt[pbir_pkg::STAT_W-1:0] = stat;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign pad_out_o = pad_out_r;
    assign pad_oe_o = pad_oe_r;
    assign array_input_path_a_o = path_a_r;
    assign array_input_path_b_o = path_b_r;

    // Checker helpers: mirror of the input element's gate history
    logic in_gate_eff;
    logic in_gate_prev_r;
    logic in_rise;

    assign in_gate_eff = in_clk_i ^ clk_inv;
    assign in_rise = in_gate_eff && !in_gate_prev_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            in_gate_prev_r <= 1'b0;
        end else begin
            in_gate_prev_r <= in_gate_eff;
        end
    end

    // Output element gate history, mirrors the cell's own edge detector
    logic out_gate_prev_r;
    logic out_rise;

    assign out_rise = out_clk_i && !out_gate_prev_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            out_gate_prev_r <= 1'b0;
        end else begin
            out_gate_prev_r <= out_clk_i;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Capture step: active edge with enable, then element shows the pin
    sequence s_ff_edge;
        !latch_mode && in_rise && in_ce && !global_set_reset_i;
    endsequence

    sequence s_latch_open;
        latch_mode && in_gate_eff && in_ce && !global_set_reset_i;
    endsequence

    sequence s_out_edge;
        out_rise && out_ce && !global_set_reset_i;
    endsequence

    a_path_a_direct: assert property (
        !a_reg |=> array_input_path_a_o == $past(pad_in_i))
        else $error("path a direct value wrong");

    a_path_b_stored: assert property (
        b_reg ##1 b_reg |=> array_input_path_b_o == $past(in_q))
        else $error("path b stored value wrong");

    a_path_a_stored: assert property (
        a_reg |=> array_input_path_a_o == $past(in_q))
        else $error("path a stored value wrong");

    a_ff_capture_edge: assert property (
        s_ff_edge |=> in_q == $past(pad_in_i)
        ##1 (!$past(a_reg) || array_input_path_a_o == $past(in_q)))
        else $error("flop missed edge capture");

    a_ff_hold_no_edge: assert property (
        (!latch_mode && !in_rise && !global_set_reset_i) |=> $stable(in_q))
        else $error("flop changed without edge");

    a_latch_pass_open: assert property (
        s_latch_open |=> in_q == $past(pad_in_i))
        else $error("latch not transparent");

    a_latch_hold_closed: assert property (
        (latch_mode && !in_gate_eff && !global_set_reset_i) |=> $stable(in_q))
        else $error("latch changed while closed");

    a_ce_low_hold: assert property (
        (ce_used && ce_to_in && !clk_en_i && !global_set_reset_i) |=> $stable(in_q))
        else $error("element changed with enable low");

    a_gsr_init_value: assert property (
        global_set_reset_i |=> in_q == $past(init_set) && out_q == $past(init_set))
        else $error("init value not loaded");

    a_ce_default_on: assert property (
        (!ce_used && !latch_mode && in_rise && !global_set_reset_i)
        |=> in_q == $past(pad_in_i))
        else $error("unused enable blocked capture");

    a_oe_by_dir: assert property (
        (dir == pbir_pkg::PBIR_DIR_IN) ##1 (dir == pbir_pkg::PBIR_DIR_IN) |-> !pad_oe_o)
        else $error("input pin driven");

    a_out_ce_hold: assert property (
        (ce_used && ce_to_out && !clk_en_i && !global_set_reset_i) |=> $stable(out_q))
        else $error("output element ignored enable");

    a_cfg_readback: assert property (
        (reg_rd_i && reg_addr_i == pbir_pkg::CFG_OFFS)
        |=> reg_rdata_o[pbir_pkg::CFG_W-1:0] == $past(cfg_r))
        else $error("config readback wrong");

    a_path_b_direct: assert property (
        !b_reg |=> array_input_path_b_o == $past(pad_in_i))
        else $error("path b direct value wrong");

    a_ce_unrouted_in: assert property (
        (!ce_to_in && !latch_mode && in_rise && !global_set_reset_i)
        |=> in_q == $past(pad_in_i))
        else $error("input element gated by unrouted enable");

    // Output element, always a plain rising-edge flop
    a_out_ff_capture: assert property (
        s_out_edge |=> out_q == $past(out_data_i))
        else $error("output flop missed edge capture");

    a_out_hold_idle: assert property (
        (!out_rise && !global_set_reset_i) |=> $stable(out_q))
        else $error("output flop changed without edge");

    a_pad_out_direct: assert property (
        !out_reg |=> pad_out_o == $past(out_data_i))
        else $error("direct pin drive wrong");

    a_pad_out_stored: assert property (
        out_reg |=> pad_out_o == $past(out_q))
        else $error("stored pin drive wrong");

    a_oe_out_mode: assert property (
        (dir == pbir_pkg::PBIR_DIR_OUT) |=> pad_oe_o)
        else $error("output pin not driven");

    a_oe_bidir_tri: assert property (
        (dir == pbir_pkg::PBIR_DIR_BIDIR) |=> pad_oe_o != $past(out_tri_i))
        else $error("bidir driver ignores tri control");

    // The spare direction code must never fight an outside driver
    a_dir_spare_in: assert property (
        (cfg_r[pbir_pkg::CFG_DIR_LSB +: 2] == 2'h3) |=> !pad_oe_o)
        else $error("spare direction code drives pin");

    // Power-up leaves the reset value selected and loaded
    a_init_after_reset: assert property (
        $fell(rst_i) |-> !init_set && !in_q && !out_q)
        else $error("power-up init value wrong");

    // Register port answers
    a_rdata_idle_zero: assert property (
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data outside read cycle");

    a_stat_readback: assert property (
        (reg_rd_i && reg_addr_i == pbir_pkg::STAT_OFFS)
        |=> reg_rdata_o[pbir_pkg::STAT_W-1:0] == $past(stat))
        else $error("status readback wrong");

    a_unmapped_zero: assert property (
        (reg_rd_i && reg_addr_i != pbir_pkg::CFG_OFFS && reg_addr_i != pbir_pkg::STAT_OFFS)
        |=> reg_rdata_o == '0)
        else $error("unmapped read not zero");

endmodule // pbir_pin_block

/* File: verif/pbir_pad_source.sv */
// Pad source model: external driver standing on the package pin
`timescale 1ns/10ps
module pbir_pad_source (
    // Source side level
    input wire logic src_val_i,
    // Block pin driver
    input wire logic pad_out_i,
    input wire logic pad_oe_i,
    // Resolved pin level
    output logic pad_o
);
    // Shared pin resolution
    // Source backs off while the block drives, so the pin never carries a fight
    assign pad_o = (pad_oe_i === 1'b1) ? pad_out_i : src_val_i;
endmodule // pbir_pad_source

/* File: verif/pbir_pin_block_bench.sv */
// Self-checking bench for the pin block input capture paths
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pbir_pin_block_bench;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] FA = ONE << pbir_pkg::CFG_A_REG_BIT;
    localparam logic [31:0] FL = ONE << pbir_pkg::CFG_LATCH_BIT;
    localparam logic [31:0] FI = ONE << pbir_pkg::CFG_CLK_INV_BIT;
    localparam logic [31:0] FCI = ONE << pbir_pkg::CFG_CE_IN_BIT;
    localparam logic [31:0] FCO = ONE << pbir_pkg::CFG_CE_OUT_BIT;
    localparam logic [31:0] FCU = ONE << pbir_pkg::CFG_CE_USED_BIT;
    localparam logic [31:0] FS = ONE << pbir_pkg::CFG_INIT_SET_BIT;
    localparam logic [31:0] FD = ONE << pbir_pkg::CFG_DIR_LSB;
    localparam logic [31:0] FB = 32'h0000_0002 << pbir_pkg::CFG_DIR_LSB;
    localparam logic [31:0] FBR = ONE << pbir_pkg::CFG_B_REG_BIT;
    localparam logic [31:0] FO = ONE << pbir_pkg::CFG_OUT_REG_BIT;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [pbir_pkg::ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [pbir_pkg::DATA_W-1:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [pbir_pkg::DATA_W-1:0] reg_rdata_o;
    logic pad_in_i;
    logic pad_out_o;
    logic pad_oe_o;
    logic src_val = 1'b0;
    logic gsr_i = 1'b0;
    logic in_clk_i = 1'b0;
    logic out_clk_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic out_data_i = 1'b1;
    logic out_tri_i = 1'b0;
    logic array_input_path_a_o;
    logic array_input_path_b_o;
    int mismatches = 0;
    int cmp_count = 0;

    // Clock, 50 ns period
    always #25 mclk_i = ~mclk_i;

    pbir_pin_block u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
        .pad_oe_o(pad_oe_o), .global_set_reset_i(gsr_i), .in_clk_i(in_clk_i),
        .out_clk_i(out_clk_i), .clk_en_i(clk_en_i), .out_data_i(out_data_i),
        .out_tri_i(out_tri_i), .array_input_path_a_o(array_input_path_a_o),
        .array_input_path_b_o(array_input_path_b_o));

    pbir_pad_source u_src (.src_val_i(src_val), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pad_o(pad_in_i));

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= pbir_pkg::CFG_OFFS;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        // Look mid-cycle, while the answer stands
        @(negedge mclk_i);
        `CHK(n, e, reg_rdata_o)
    endtask

    // Pin level change, then settle time for the one-cycle paths
    task automatic pad(input logic v);
        @(posedge mclk_i);
        src_val <= v;
        step(4);
    endtask

    // Both element clocks go to v, then back
    task automatic pulse(input logic v);
        @(posedge mclk_i);
        in_clk_i <= v;
        out_clk_i <= v;
        step(4);
        in_clk_i <= ~v;
        out_clk_i <= ~v;
        step(4);
    endtask

    task automatic global_set_reset();
        @(posedge mclk_i);
        gsr_i <= 1'b1;
        @(posedge mclk_i);
        gsr_i <= 1'b0;
        step(4);
    endtask

    task automatic pa(input logic e);
        `CHK("path_a", e, array_input_path_a_o)
    endtask

    task automatic pb(input logic e);
        `CHK("path_b", e, array_input_path_b_o)
    endtask

    // Watchdog well past the fewer than two hundred cycles the tests need
    initial begin
        step(20000);
        mismatches++;
        complete_run();
    end

    // Main sequence
    initial begin
        step(8);
        rst_i <= 1'b0;
        step(2);
        rd(pbir_pkg::CFG_OFFS, 32'(pbir_pkg::CFG_RST), "cfg");
        rd(8'h08, 32'h0000_0000, "unmapped");
        `CHK("oe_in", 1'b0, pad_oe_o)
        wr(FA | FCI | FCU);
        pad(1'b1);
        pulse(1'b1);
        pa(1'b1);
        pb(1'b1);
        rd(pbir_pkg::STAT_OFFS, 32'h0000_001F, "status");
        pad(1'b0);
        pa(1'b1);
        pb(1'b0);
        clk_en_i <= 1'b0;
        pulse(1'b1);
        pa(1'b1);
        clk_en_i <= 1'b1;
        pulse(1'b1);
        pa(1'b0);
        // Raise the clock before inverting so the config change is no edge
        pad(1'b1);
        in_clk_i <= 1'b1;
        pad(1'b0);
        wr(FA | FI | FCI | FCU);
        step(3);
        pa(1'b1);
        pulse(1'b0);
        pa(1'b0);
        wr(FA | FL | FCI | FCU);
        pad(1'b1);
        pa(1'b1);
        pad(1'b0);
        pa(1'b0);
        in_clk_i <= 1'b0;
        pad(1'b1);
        pa(1'b0);
        clk_en_i <= 1'b0;
        in_clk_i <= 1'b1;
        step(4);
        pa(1'b0);
        wr(FA | FS | FCI | FCU);
        global_set_reset();
        pa(1'b1);
        wr(FA | FCI | FCU);
        global_set_reset();
        pa(1'b0);
        wr(FA | FCI);
        pulse(1'b0);
        pa(1'b1);
        // Path B stored, path A direct: pin drops, stored copy stays
        wr(FBR | FCI);
        pad(1'b0);
        pb(1'b1);
        pa(1'b0);
        // Block now drives the pin with the held output element
        wr(FA | FCO | FCU | FD | FO);
        out_data_i <= 1'b0;
        pulse(1'b0);
        `CHK("oe_out", 1'b1, pad_oe_o)
        pa(1'b1);
        `CHK("pad_out", 1'b1, pad_out_o)
        clk_en_i <= 1'b1;
        pulse(1'b0);
        `CHK("pad_out", 1'b0, pad_out_o)
        pb(1'b0);
        out_tri_i <= 1'b1;
        wr(FB);
        step(3);
        `CHK("oe_bidir", 1'b0, pad_oe_o)
        out_tri_i <= 1'b0;
        step(3);
        `CHK("oe_bidir", 1'b1, pad_oe_o)
        complete_run();
    end
endmodule // pbir_pin_block_bench
